// [pkg/ascd_pkg.sv]
// Shared constants, types and field layouts of the serial command decoder
package ascd_pkg;

    // Register-select codes of a register-access command
    localparam logic [2:0] RSEL_OFFSET = 3'h1;
    localparam logic [2:0] RSEL_GAIN = 3'h2;
    localparam logic [2:0] RSEL_CONFIG = 3'h3;
    localparam logic [2:0] RSEL_FIFO = 3'h4;
    localparam logic [2:0] RSEL_SETUP = 3'h5;

    // Operation codes of a conversion or calibration command
    localparam logic [2:0] OP_NORMAL = 3'h0;
    localparam logic [2:0] OP_SELF_OFS = 3'h1;
    localparam logic [2:0] OP_SELF_GAIN = 3'h2;
    localparam logic [2:0] OP_SYS_OFS = 3'h5;
    localparam logic [2:0] OP_SYS_GAIN = 3'h6;

    // Channel-setup array geometry, eight-channel variant
    localparam int NUM_SETUP_WORDS = 8;
    localparam int SETUP_W = 24;
    localparam logic [SETUP_W-1:0] SETUP_RST = 24'h000000;

    // Data-mode lengths in bytes
    localparam logic [4:0] SETUP_BYTES = 5'h18;
    localparam logic [4:0] REG_BYTES = 5'h03;
    localparam logic [4:0] CONV_BYTES = 5'h03;
    localparam logic [1:0] LAST_LANE = 2'h2;

    // Port initialisation sequence
    localparam logic [3:0] INIT_FF_COUNT = 4'hF;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [7:0] INIT_BYTE = 8'hFE;

    // Register-access command layout, bit 7 first
    typedef struct packed {
        logic command_class_bit;
        logic [2:0] phys_chan_addr;
        logic read_not_write;
        logic [2:0] reg_select;
    } ascd_regcmd_s;

    // Conversion or calibration command layout, bit 7 first
    typedef struct packed {
        logic command_class_bit;
        logic [3:0] logical_chan_pointer;
        logic [2:0] operation_code;
    } ascd_opcmd_s;

    // One logical channel, twelve bits of a setup word
    typedef struct packed {
        logic [1:0] latch_out_bits;
        logic [2:0] setup_phys_chan;
        logic [2:0] word_rate_sel;
        logic [2:0] gain_range_sel;
        logic unipolar;
    } ascd_entry_s;

    // Register access handed to the register file
    typedef struct packed {
        logic valid;
        logic rd;
        logic [2:0] reg_select;
        logic [2:0] phys_chan;
    } ascd_reg_req_s;

    // Conversion or calibration start
    typedef struct packed {
        logic valid;
        logic is_cal;
        logic use_pointer;
        logic [3:0] pointer;
        logic [2:0] op;
    } ascd_op_req_s;

    // Port mode
    typedef enum logic {
        ST_CMD = 1'b0,
        ST_DATA = 1'b1
    } ascd_state_e;

endpackage

// [core/ascd_link_rx.sv]
// Serial-clock side byte receiver of the command decoder
module ascd_link_rx
    import ascd_pkg::*;
(
    input wire logic sclk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sdi,
    output logic [7:0] rx_byte,
    output logic rx_toggle
);

    logic [2:0] bit_cnt_reg; // Bits taken in current byte
    logic [6:0] shift_reg; // Partial byte
    logic [7:0] byte_reg; // Last whole byte, stable for 8 bit times
    logic toggle_reg; // Flips once per whole byte

    // Bit position; chip select high drops any partial byte
    always_ff @(posedge sclk or posedge cs_n or posedge sys_rst) begin
        if (sys_rst || cs_n) begin
            bit_cnt_reg <= 3'h0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // MSB first shift, one bit per rising serial clock
    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_reg <= 7'h00;
            byte_reg <= 8'h00;
            toggle_reg <= 1'b0;
        end else if (!cs_n) begin
            shift_reg <= {shift_reg[5:0], sdi};
            if (bit_cnt_reg == 3'h7) begin
                // Toggle survives chip select so no byte is counted twice
                byte_reg <= {shift_reg, sdi};
                toggle_reg <= ~toggle_reg;
            end
        end
    end

    assign rx_byte = byte_reg;
    assign rx_toggle = toggle_reg;

endmodule

// [core/ascd_decoder.sv]
// Command decoder of a multi-channel converter serial port
// Function
// - MSB zero means register access
// - MSB one means conversion or calibration
// - Bits 6..4 give physical channel
// - Physical channel picks offset or gain register
// - FIFO read ignores physical channel field
// - Bit 3: zero writes, one reads
// - Low bits select register; some reserved
// - Setup array length follows channel variant
// - Bits 6..3 give logical channel pointer
// - Pointer used only when multi-conversion clear
// - Calibration ignores loop, multi, read-convert bits; code still lets multi drop the calibration pointer
// - Low bits select conversion or calibration
// - Setup word holds two twelve-bit entries
// - First byte is command; most enter data
// - Fifteen FF then init byte resynchronise
// - Setup access moves even channel count
// - Latch pins follow entry in use
module ascd_decoder
    import ascd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic multi_conv_bit,
    input wire logic loop_bit,
    input wire logic read_convert_bit,
    input wire logic op_done,
    output logic data_mode,
    output ascd_reg_req_s reg_req,
    output ascd_op_req_s op_req,
    output logic [7:0] wr_data,
    output logic wr_data_valid,
    output logic [1:0] latch_out_bits,
    output logic loop_eff,
    output logic multi_conv_eff,
    output logic read_convert_eff
);

    logic [7:0] rx_byte; // Byte held by the link side
    logic rx_toggle; // Byte event from the link side
    logic tgl_s1_reg; // Synchroniser first stage
    logic tgl_s2_reg; // Synchroniser second stage
    logic tgl_s3_reg; // Edge detect delay
    logic byte_stb; // One cycle per received byte
    ascd_regcmd_s rcmd; // Byte seen as register access
    ascd_opcmd_s ocmd; // Byte seen as operation
    logic init_hit; // Resync sequence complete
    logic sel_ok; // Register select is usable
    logic op_ok; // Operation code is usable
    logic reg_go; // Accept register access
    logic op_go; // Accept operation
    logic [3:0] ff_cnt_reg; // Run of fill bytes
    ascd_state_e state_reg; // Command or data mode
    logic [4:0] left_reg; // Data bytes still due
    logic conv_reg; // Data mode carries conversion words
    logic setup_wr_reg; // Data mode writes setup array
    logic reg_wr_reg; // Data mode writes a plain register
    logic [1:0] lane_reg; // Byte within setup word
    logic [2:0] word_reg; // Setup word being written
    logic [15:0] asm_reg; // Upper bytes of setup word
    logic [SETUP_W-1:0] setup_mem [NUM_SETUP_WORDS]; // Setup array
    logic [3:0] active_ptr_reg; // Logical channel in use
    logic cal_busy_reg; // Calibration running
    ascd_reg_req_s reg_req_reg;
    ascd_op_req_s op_req_reg;
    logic [7:0] wr_data_reg;
    logic wr_data_valid_reg;
    logic [1:0] latch_reg;
    logic loop_eff_reg;
    logic multi_eff_reg;
    logic rdcv_eff_reg;
    ascd_entry_s hi_entry; // Entry at bits 23..12
    ascd_entry_s lo_entry; // Entry at bits 11..0

    // Receiver on the host's serial clock
    ascd_link_rx u_rx (
        .sclk(sclk),
        .sys_rst(sys_rst),
        .cs_n(cs_n),
        .sdi(sdi),
        .rx_byte(rx_byte),
        .rx_toggle(rx_toggle)
    );

    // Toggle crossing; byte is stable far longer than the sync delay
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
            tgl_s3_reg <= 1'b0;
        end else begin
            tgl_s1_reg <= rx_toggle;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
        end
    end

    assign byte_stb = tgl_s2_reg ^ tgl_s3_reg;
    assign rcmd = ascd_regcmd_s'(rx_byte);
    assign ocmd = ascd_opcmd_s'(rx_byte);
    assign init_hit = byte_stb && (ff_cnt_reg == INIT_FF_COUNT)
        && (rx_byte == INIT_BYTE);

    // Command decode; reserved codes are dropped as no-ops
    always_comb begin
        case (rcmd.reg_select)
            RSEL_OFFSET, RSEL_GAIN, RSEL_CONFIG, RSEL_SETUP: begin
                sel_ok = 1'b1;
            end
            RSEL_FIFO: begin
                sel_ok = rcmd.read_not_write;
            end
            default: begin
                sel_ok = 1'b0;
            end
        endcase
        case (ocmd.operation_code)
            OP_NORMAL, OP_SELF_OFS, OP_SELF_GAIN, OP_SYS_OFS,
            OP_SYS_GAIN: begin
                op_ok = 1'b1;
            end
            default: begin
                op_ok = 1'b0;
            end
        endcase
        reg_go = byte_stb && (state_reg == ST_CMD) && !init_hit
            && !rcmd.command_class_bit && sel_ok;
        op_go = byte_stb && (state_reg == ST_CMD) && !init_hit
            && ocmd.command_class_bit && op_ok;
    end

    // Fill-byte run counter, saturating at fifteen
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ff_cnt_reg <= 4'h0;
        end else if (byte_stb) begin
            if (rx_byte != FILL_BYTE) begin
                ff_cnt_reg <= 4'h0;
            end else if (ff_cnt_reg != INIT_FF_COUNT) begin
                ff_cnt_reg <= ff_cnt_reg + 4'h1;
            end
        end
    end

    // Port mode and data-mode length
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_CMD;
            left_reg <= 5'h00;
            conv_reg <= 1'b0;
            setup_wr_reg <= 1'b0;
            reg_wr_reg <= 1'b0;
        end else if (init_hit) begin
            // Resync wins even in the middle of data
            state_reg <= ST_CMD;
            left_reg <= 5'h00;
        end else if (reg_go) begin
            state_reg <= ST_DATA;
            // Whole array only, so channels move in pairs
            left_reg <= (rcmd.reg_select == RSEL_SETUP) ?
                SETUP_BYTES : REG_BYTES;
            conv_reg <= 1'b0;
            setup_wr_reg <= (rcmd.reg_select == RSEL_SETUP)
                && !rcmd.read_not_write;
            reg_wr_reg <= (rcmd.reg_select != RSEL_SETUP)
                && !rcmd.read_not_write;
        end else if (op_go && (ocmd.operation_code == OP_NORMAL)) begin
            state_reg <= ST_DATA;
            left_reg <= CONV_BYTES;
            conv_reg <= 1'b1;
            setup_wr_reg <= 1'b0;
            reg_wr_reg <= 1'b0;
        end else if ((state_reg == ST_DATA) && byte_stb) begin
            if (left_reg != 5'h01) begin
                left_reg <= left_reg - 5'h01;
            end else if (conv_reg && loop_eff_reg) begin
                // Looping conversions keep the port in data mode
                left_reg <= CONV_BYTES;
            end else begin
                state_reg <= ST_CMD;
                left_reg <= 5'h00;
            end
        end
    end

    // Setup-word assembly, three bytes per word, MSB first
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lane_reg <= 2'h0;
            word_reg <= 3'h0;
            asm_reg <= 16'h0000;
        end else if (reg_go) begin
            lane_reg <= 2'h0;
            word_reg <= 3'h0;
        end else if ((state_reg == ST_DATA) && byte_stb && setup_wr_reg) begin
            asm_reg <= {asm_reg[7:0], rx_byte};
            if (lane_reg == LAST_LANE) begin
                lane_reg <= 2'h0;
                word_reg <= word_reg + 3'h1;
            end else begin
                lane_reg <= lane_reg + 2'h1;
            end
        end
    end

    // One write port per setup word
    genvar g;
    generate
        for (g = 0; g < NUM_SETUP_WORDS; g++) begin : g_setup
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    setup_mem[g] <= SETUP_RST;
                end else if ((state_reg == ST_DATA) && byte_stb
                    && setup_wr_reg && (lane_reg == LAST_LANE)
                    && (word_reg == 3'(g))) begin
                    setup_mem[g] <= {asm_reg, rx_byte};
                end
            end
        end
    endgenerate

    // Register access request, one cycle per command
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_req_reg <= '0;
        end else begin
            reg_req_reg.valid <= reg_go;
            reg_req_reg.rd <= rcmd.read_not_write;
            reg_req_reg.reg_select <= rcmd.reg_select;
            // Channel only matters for calibration registers
            if ((rcmd.reg_select == RSEL_OFFSET)
                || (rcmd.reg_select == RSEL_GAIN)) begin
                reg_req_reg.phys_chan <= rcmd.phys_chan_addr;
            end else begin
                reg_req_reg.phys_chan <= 3'h0;
            end
        end
    end

    // Plain register write data, one pulse per byte
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_data_reg <= 8'h00;
            wr_data_valid_reg <= 1'b0;
        end else begin
            wr_data_reg <= rx_byte;
            wr_data_valid_reg <= (state_reg == ST_DATA) && byte_stb
                && reg_wr_reg && !init_hit;
        end
    end

    // Operation request and logical channel in use
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            op_req_reg <= '0;
            active_ptr_reg <= 4'h0;
        end else begin
            op_req_reg.valid <= op_go;
            op_req_reg.op <= ocmd.operation_code;
            op_req_reg.is_cal <= (ocmd.operation_code != OP_NORMAL);
            op_req_reg.use_pointer <= !multi_conv_bit;
            op_req_reg.pointer <= multi_conv_bit ? 4'h0 :
                ocmd.logical_chan_pointer;
            if (op_go) begin
                // Sequencer starts at the first entry when pointer ignored
                active_ptr_reg <= multi_conv_bit ? 4'h0 :
                    ocmd.logical_chan_pointer;
            end
        end
    end

    // Calibration busy; start wins over a same-cycle done
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_busy_reg <= 1'b0;
        end else if (op_go && (ocmd.operation_code != OP_NORMAL)) begin
            cal_busy_reg <= 1'b1;
        end else if (op_done) begin
            cal_busy_reg <= 1'b0;
        end
    end

    // Configuration bits as seen by the sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loop_eff_reg <= 1'b0;
            multi_eff_reg <= 1'b0;
            rdcv_eff_reg <= 1'b0;
        end else begin
            loop_eff_reg <= loop_bit && !cal_busy_reg;
            multi_eff_reg <= multi_conv_bit && !cal_busy_reg;
            rdcv_eff_reg <= read_convert_bit && !cal_busy_reg;
        end
    end

    // Even pointer uses the upper twelve bits of its word
    assign hi_entry = ascd_entry_s'(setup_mem[active_ptr_reg[3:1]][23:12]);
    assign lo_entry = ascd_entry_s'(setup_mem[active_ptr_reg[3:1]][11:0]);

    // Latch pins follow the entry in use
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            latch_reg <= 2'h0;
        end else begin
            latch_reg <= active_ptr_reg[0] ? lo_entry.latch_out_bits :
                hi_entry.latch_out_bits;
        end
    end

    assign data_mode = state_reg;
    assign reg_req = reg_req_reg;
    assign op_req = op_req_reg;
    assign wr_data = wr_data_reg;
    assign wr_data_valid = wr_data_valid_reg;
    assign latch_out_bits = latch_reg;
    assign loop_eff = loop_eff_reg;
    assign multi_conv_eff = multi_eff_reg;
    assign read_convert_eff = rdcv_eff_reg;

    // Checks in the core clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_reg_class_take: assert property (
        byte_stb && !state_reg && !rx_byte[7] && sel_ok && !init_hit
        |=> reg_req_reg.valid && state_reg)
        else $error("register command not accepted");
    a_op_class_take: assert property (
        byte_stb && !state_reg && rx_byte[7] && op_ok && !init_hit
        |=> op_req_reg.valid && (op_req_reg.op == $past(rx_byte[2:0])))
        else $error("operation command not accepted");
    a_gain_chan_pass: assert property (
        reg_req_reg.valid && (reg_req_reg.reg_select == RSEL_GAIN)
        |-> reg_req_reg.phys_chan == $past(rx_byte[6:4]))
        else $error("gain access lost channel");
    a_fifo_chan_zero: assert property (
        reg_req_reg.valid && (reg_req_reg.reg_select == RSEL_FIFO)
        |-> (reg_req_reg.phys_chan == 3'h0) && reg_req_reg.rd)
        else $error("fifo access kept channel");
    a_dir_bit_follow: assert property (
        reg_req_reg.valid |-> reg_req_reg.rd == $past(rx_byte[3]))
        else $error("direction bit wrong");
    a_setup_len_load: assert property (
        reg_req_reg.valid && (reg_req_reg.reg_select == RSEL_SETUP)
        |-> left_reg == SETUP_BYTES)
        else $error("setup length wrong");
    a_pointer_gate_mc: assert property (
        op_go && multi_conv_bit |=> (op_req_reg.pointer == 4'h0)
        && !op_req_reg.use_pointer && (active_ptr_reg == 4'h0))
        else $error("pointer used with multi conversion");
    a_cal_cfg_mask: assert property (
        cal_busy_reg |=> !loop_eff_reg && !multi_eff_reg && !rdcv_eff_reg)
        else $error("config bit passed during calibration");
    a_cal_stays_cmd: assert property (
        op_req_reg.valid && op_req_reg.is_cal |-> !state_reg)
        else $error("calibration entered data mode");
    a_init_resync_cmd: assert property (
        init_hit |=> !state_reg [*2])
        else $error("resync did not restore command mode");
    a_latch_follow_ptr: assert property (
        $stable(active_ptr_reg) && !active_ptr_reg[0]
        |=> latch_out_bits == $past(hi_entry.latch_out_bits))
        else $error("latch pins not following entry");

    c_cal_start: cover property (op_req_reg.valid && op_req_reg.is_cal);
    c_setup_word: cover property (setup_wr_reg && byte_stb
        && (lane_reg == LAST_LANE));
    c_resync: cover property (init_hit && state_reg);
    c_conv_data: cover property (op_req_reg.valid ##[1:60] !state_reg);

endmodule

// [verif/ascd_host_model.sv]
// Host-side serial master model driving the command port
module ascd_host_model (
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ns;

    localparam int HALF = 40; // Half of the 80 ns serial clock
    logic last_bit; // Last bit shifted, inverted once released

    // Idle: deselected, clock parked low, data line not valid
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b1;
        last_bit = 1'b0;
    end

    // Select the port and give it half a period before the first bit
    task automatic open_frame();
        cs_n = 1'b0;
        #HALF;
    endtask

    // Deselect; data line shows junk so stale bits cannot pass
    task automatic close_frame();
        #HALF;
        cs_n = 1'b1;
        sdi = ~last_bit;
        #HALF;
    endtask

    // Shift the top n bits, MSB first, data changed while clock low
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            sdi = b[i];
            last_bit = b[i];
            #HALF;
            sclk = 1'b1;
            #HALF;
            sclk = 1'b0;
        end
    endtask

    // Whole byte
    task automatic send_byte(input logic [7:0] b);
        send_bits(b, 8);
    endtask

    // Resynchronising sequence: fill bytes then the init byte
    task automatic resync();
        repeat (15) send_byte(8'hFF);
        send_byte(8'hFE);
    endtask
endmodule

// [verif/tb_top.sv]
// Self-checking bench of the serial command decoder
module tb_top
    import ascd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, sys_rst, sclk, cs_n, sdi; // Clocks, reset, serial pins
    logic multi_conv_bit, loop_bit, read_convert_bit, op_done; // Config
    logic data_mode, wr_data_valid, loop_eff, multi_conv_eff;
    logic read_convert_eff;
    ascd_reg_req_s reg_req; // Register access out
    ascd_op_req_s op_req; // Operation start out
    logic [7:0] wr_data;
    logic [1:0] latch_out_bits;
    logic [11:0] exp_q[$]; // Expected results: kind then payload
    logic [7:0] setup_b[24]; // Bytes written to the setup array
    logic [15:0] rnd = 16'h0C44; // Random source state
    int mismatches = 0;
    int num_checks = 0;

    ascd_host_model i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));

    ascd_decoder i_dut (
        .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .multi_conv_bit(multi_conv_bit), .loop_bit(loop_bit),
        .read_convert_bit(read_convert_bit), .op_done(op_done),
        .data_mode(data_mode), .reg_req(reg_req), .op_req(op_req),
        .wr_data(wr_data), .wr_data_valid(wr_data_valid),
        .latch_out_bits(latch_out_bits), .loop_eff(loop_eff),
        .multi_conv_eff(multi_conv_eff),
        .read_convert_eff(read_convert_eff)
    );

    // Core clock, 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Next random byte from the shift register
    function automatic logic [7:0] rand8();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return rnd[7:0];
    endfunction

    // Compare and count; X never matches
    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Pair a seen result with the oldest note; none means refusal broken
    task automatic take(input logic [11:0] got);
        if (exp_q.size() == 0) begin
            check("unexpected result", got, 12'h000);
        end else begin
            check("result", got, exp_q.pop_front());
        end
    endtask

    // Monitor: pulses stand one cycle, so sample mid-cycle
    always @(negedge clk) begin
        if (reg_req.valid === 1'b1) take({5'h08, reg_req[6:0]});
        if (op_req.valid === 1'b1) take({3'h4, op_req[8:0]});
        if (wr_data_valid === 1'b1) take({4'hC, wr_data});
    end

    // Covers the sync delay plus the request register
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask

    // One register access frame with its data bytes
    task automatic reg_cmd(input logic rd, input logic [2:0] sel);
        logic [7:0] b;
        logic [2:0] chan;
        logic ok;
        int n;
        b = rand8();
        chan = b[2:0];
        ok = sel != 3'h0 && sel < 3'h6 && !(sel == RSEL_FIFO && !rd);
        n = (sel == RSEL_SETUP) ? 24 : 3;
        if (ok) begin
            exp_q.push_back({5'h08, rd, sel, (sel == RSEL_OFFSET ||
                sel == RSEL_GAIN) ? chan : 3'h0});
        end
        i_host.open_frame();
        i_host.send_byte({1'b0, chan, rd, sel});
        settle();
        check("data_mode", data_mode, ok);
        for (int i = 0; ok && i < n; i++) begin
            b = rand8();
            if (sel == RSEL_SETUP && !rd) setup_b[i] = b;
            if (!rd && sel != RSEL_SETUP) exp_q.push_back({4'hC, b});
            i_host.send_byte(b);
            if (i >= n - 2) begin
                settle();
                check("data_mode", data_mode, i < n - 1);
            end
        end
        i_host.close_frame();
    endtask

    // One conversion or calibration frame
    task automatic op_cmd(input logic [2:0] op);
        logic [7:0] r;
        logic [3:0] idx;
        logic mconv, cal, ok;
        r = rand8();
        mconv = r[7];
        cal = op == OP_SELF_OFS || op == OP_SELF_GAIN ||
              op == OP_SYS_OFS || op == OP_SYS_GAIN;
        ok = cal || op == OP_NORMAL;
        idx = mconv ? 4'h0 : r[3:0];
        @(negedge clk);
        multi_conv_bit = mconv;
        loop_bit = cal;
        read_convert_bit = cal;
        if (ok) exp_q.push_back({3'h4, cal, !mconv, idx, op});
        i_host.open_frame();
        i_host.send_byte({1'b1, r[3:0], op});
        settle();
        check("data_mode", data_mode, op == OP_NORMAL);
        if (op == OP_NORMAL) begin
            check("latch", latch_out_bits, idx[0] ?
                setup_b[3 * idx[3:1] + 1][3:2] :
                setup_b[3 * idx[3:1]][7:6]);
            repeat (3) i_host.send_byte(rand8());
            settle();
            check("data_mode", data_mode, 12'h0);
        end
        if (cal) begin
            check("cfg", {loop_eff, multi_conv_eff, read_convert_eff},
                12'h0);
            op_done = 1'b1;
            @(negedge clk);
            op_done = 1'b0;
            settle();
            check("cfg", {loop_eff, multi_conv_eff, read_convert_eff},
                {2'h1, mconv, 1'b1});
            loop_bit = 1'b0;
            read_convert_bit = 1'b0;
        end
        i_host.close_frame();
    endtask

    // Verdict, shared by the main sequence and the watchdog
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog, well above the expected run of about 140 us
    initial begin
        #2000000;
        mismatches++;
        finish_test();
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        multi_conv_bit = 1'b0;
        loop_bit = 1'b0;
        read_convert_bit = 1'b0;
        op_done = 1'b0;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        settle();
        check("data_mode", data_mode, 12'h0);
        // Partial byte cut by deselect must leave no trace
        i_host.open_frame();
        i_host.send_bits(8'h80, 3);
        i_host.close_frame();
        // Every register code in both directions, reserved ones too
        for (int s = 0; s < 8; s++) begin
            reg_cmd(1'b0, s[2:0]);
            reg_cmd(1'b1, s[2:0]);
        end
        // Every operation code twice, pointer and multi bit random
        for (int k = 0; k < 16; k++) begin
            op_cmd(k[2:0]);
        end
        // Resync in the middle of a setup write
        exp_q.push_back({5'h08, 1'b0, RSEL_SETUP, 3'h0});
        i_host.open_frame();
        i_host.send_byte(8'h05);
        i_host.send_byte(8'h3C);
        i_host.resync();
        settle();
        check("data_mode", data_mode, 12'h0);
        i_host.close_frame();
        reg_cmd(1'b1, RSEL_CONFIG);
        settle();
        check("pending", exp_q.size(), 12'h0);
        finish_test();
    end
endmodule
